// ---- design/pag_addr.sv ----
// program address former: table, remap and fetch addresses
// assumes the caller registers the results
`timescale 1ns/10ps
module pag_addr (
    input  wire logic [7:0]  table_page,
    input  wire logic [7:0]  remap_page,
    input  wire logic [15:0] effective_address,
    input  wire logic [23:0] pc,
    output logic      [23:0] table_addr,
    output logic      [23:0] remap_addr,
    output logic      [23:0] fetch_addr
);
    always_comb begin
        table_addr = {table_page, effective_address}; // RULE_01 RULE_06
        // page bit 0 lands on address bit 15, ea bit 15 dropped
        remap_addr = {1'b0, remap_page[7:1], remap_page[0],
                      effective_address[14:1], 1'b0}; // RULE_03 RULE_04 RULE_05
        fetch_addr = {1'b0, pc[22:1], 1'b0}; // RULE_05
    end
endmodule : pag_addr

// ---- design/pag_steer.sv ----
// read data steering for low and high table reads, word and byte mode
// assumes a 24-bit program word from memory
`timescale 1ns/10ps
module pag_steer (
    input  wire logic [23:0] prog_word,
    input  wire logic        high_op,
    input  wire logic        byte_mode,
    input  wire logic        byte_sel,
    output logic      [15:0] rdata
);
    always_comb begin
        rdata = 16'h0000;
        if (!high_op) begin
            if (!byte_mode) begin
                rdata = prog_word[15:0]; // RULE_07
            end else if (byte_sel) begin
                rdata = {8'h00, prog_word[15:8]}; // RULE_08
            end else begin
                rdata = {8'h00, prog_word[7:0]}; // RULE_08
            end
        end else begin
            if (!byte_mode) begin
                rdata = {8'h00, prog_word[23:16]}; // RULE_09 RULE_12
            end else if (byte_sel) begin
                rdata = 16'h0000; // RULE_10
            end else begin
                rdata = {8'h00, prog_word[23:16]}; // RULE_10 RULE_12
            end
        end
    end
endmodule : pag_steer

// ---- design/pag_top.sv ----
// program space address generator: top level
// assumes one core clock, apb register access, program memory with
// one-cycle read data and a core that honours the stall output
//
// Behaviour
// RULE_01 - table address is table page above the 16-bit effective address
// RULE_02 - table page bit 7 selects configuration, else user memory
// RULE_03 - ea msb set remaps page and ea[14:0] into user memory
// RULE_04 - remap address bit 23 zero, bit 15 from page bit 0
// RULE_05 - fetch and remap addresses have bit 0 zero; fetch bit 23 zero
// RULE_06 - table accesses are byte addressed, no alignment needed
// RULE_07 - low word read in word mode returns program bits 15:0
// RULE_08 - low byte read returns upper or lower low-word byte by select
// RULE_09 - high word read returns bits 23:16, upper data byte zero
// RULE_10 - high byte read with select 1 returns zero
// RULE_11 - config reads only in implemented area; config writes blocked
// RULE_12 - upper program byte reachable only by high table ops
// RULE_13 - program counter steps by two per program word
// RULE_14 - remap accesses read only, low 16-bit word only
// RULE_15 - remap needs ea msb set and window enable bit set
// RULE_16 - remap data read stalls one extra cycle
// RULE_17 - remap suspended while a table op is in progress
// RULE_18 - other data accesses go to data memory untranslated
`timescale 1ns/10ps
module pag_top (
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    // apb
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // core side
    input  wire logic        FETCH_REQ,
    input  wire logic        PC_ADVANCE,
    input  wire logic        DATA_REQ,
    input  wire logic        DATA_WRITE,
    input  wire logic [15:0] EFFECTIVE_ADDRESS,
    input  wire logic [2:0]  TABLE_OP,
    input  wire logic        BYTE_MODE,
    input  wire logic [15:0] TABLE_WDATA,
    output logic      [15:0] CORE_RDATA,
    output logic             CORE_STALL,
    // program memory side
    output logic      [23:0] PROG_ADDR,
    output logic             PROG_RD,
    output logic             PROG_WR,
    output logic             PROG_CFG,
    output logic      [23:0] PROG_WDATA,
    output logic      [2:0]  PROG_WLANES,
    input  wire logic [23:0] PROG_RDATA,
    // data memory side
    output logic      [15:0] DMEM_ADDR,
    output logic             DMEM_RD,
    output logic             DMEM_WR
);
    // ==========================================================
    // registers
    logic [7:0]  table_page_reg_q, table_page_reg_d;
    logic [7:0]  remap_page_reg_q, remap_page_reg_d;
    logic [15:0] core_control_reg_q, core_control_reg_d;
    logic [23:0] pc_q, pc_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        cfg_blocked_q, cfg_blocked_d;
    logic        apb_wr;
    logic        program_window_enable;
    assign apb_wr = PSEL && PENABLE && pready_q && PWRITE;
    assign program_window_enable =
        core_control_reg_q[pag_pkg::WIN_EN_BIT];
    // ==========================================================
    // apb slave: one wait state (answer on second access edge)
    always_comb begin
        table_page_reg_d   = table_page_reg_q;
        remap_page_reg_d   = remap_page_reg_q;
        core_control_reg_d = core_control_reg_q;
        prdata_d           = prdata_q;
        pready_d           = 1'b0;
        pslverr_d          = 1'b0;
        if (PSEL && PENABLE) begin
            pready_d = !pready_q;
            prdata_d = 32'h0000_0000;
            case (PADDR)
                pag_pkg::TABLE_PAGE_OFS: begin
                    if (apb_wr) table_page_reg_d = PWDATA[7:0];
                    prdata_d[7:0] = table_page_reg_q;
                end
                pag_pkg::REMAP_PAGE_OFS: begin
                    if (apb_wr) remap_page_reg_d = PWDATA[7:0];
                    prdata_d[7:0] = remap_page_reg_q;
                end
                pag_pkg::CORE_CTRL_OFS: begin
                    if (apb_wr) core_control_reg_d = PWDATA[15:0];
                    prdata_d[15:0] = core_control_reg_q;
                end
                pag_pkg::STATUS_OFS: begin
                    prdata_d = {7'h00, cfg_blocked_q, pc_q};
                end
                default: begin
                    pslverr_d = !pready_q;
                end
            endcase
            if (pready_q) prdata_d = prdata_q;
        end
    end
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            table_page_reg_q   <= pag_pkg::TABLE_PAGE_RST;
            remap_page_reg_q   <= pag_pkg::REMAP_PAGE_RST;
            core_control_reg_q <= pag_pkg::CORE_CTRL_RST;
            prdata_q           <= 32'h0000_0000;
            pready_q           <= 1'b0;
            pslverr_q          <= 1'b0;
        end else begin
            table_page_reg_q   <= table_page_reg_d;
            remap_page_reg_q   <= remap_page_reg_d;
            core_control_reg_q <= core_control_reg_d;
            prdata_q           <= prdata_d;
            pready_q           <= pready_d;
            pslverr_q          <= pslverr_d;
        end
    end
    // ==========================================================
    // address formation and steering
    logic [23:0] table_addr, remap_addr, fetch_addr;
    logic [15:0] steer_data;
    logic        rd_high_q, rd_high_d;
    logic        byte_sel_q, byte_sel_d;
    logic        byte_mode_q, byte_mode_d;
    pag_addr u_addr (
        .table_page        (table_page_reg_q),
        .remap_page        (remap_page_reg_q),
        .effective_address (EFFECTIVE_ADDRESS),
        .pc                (pc_q),
        .table_addr        (table_addr),
        .remap_addr        (remap_addr),
        .fetch_addr        (fetch_addr)
    );
    pag_steer u_steer (
        .prog_word (PROG_RDATA),
        .high_op   (rd_high_q),
        .byte_mode (byte_mode_q),
        .byte_sel  (byte_sel_q),
        .rdata     (steer_data)
    );
    // ==========================================================
    // access control
    pag_pkg::pag_op_e  op;
    pag_pkg::pag_state_e state_q, state_d;
    logic        table_busy, is_write, is_cfg, cfg_impl, remap_hit;
    logic [23:0] prog_addr_d, prog_wdata_d;
    logic        prog_rd_d, prog_wr_d, prog_cfg_d, stall_d;
    logic [2:0]  prog_wlanes_d;
    logic [15:0] dmem_addr_d;
    logic        dmem_rd_d, dmem_wr_d;
    logic        remap_rd_q, remap_rd_d;
    logic        tbl_rd_q, tbl_rd_d;
    logic [15:0] core_rdata_q, core_rdata_d;
    assign op = pag_pkg::pag_op_e'(TABLE_OP);
    assign table_busy = (op != pag_pkg::PAG_OP_NONE);
    assign is_write = (op == pag_pkg::PAG_OP_WR_LOW) ||
                      (op == pag_pkg::PAG_OP_WR_HIGH);
    assign is_cfg = table_page_reg_q[pag_pkg::PAGE_CFG]; // RULE_02
    assign cfg_impl = ({table_addr[23:1], 1'b0} >= pag_pkg::CFG_IMPL_LO) &&
                      ({table_addr[23:1], 1'b0} <= pag_pkg::CFG_IMPL_HI);
    assign remap_hit = DATA_REQ && !DATA_WRITE && !table_busy &&
                       program_window_enable &&
                       EFFECTIVE_ADDRESS[pag_pkg::EA_MSB]; // RULE_15 RULE_17 RULE_14
    always_comb begin
        prog_addr_d   = fetch_addr;
        prog_rd_d     = 1'b0;
        prog_wr_d     = 1'b0;
        prog_cfg_d    = 1'b0;
        prog_wdata_d  = 24'h000000;
        prog_wlanes_d = 3'b000;
        dmem_addr_d   = EFFECTIVE_ADDRESS;
        dmem_rd_d     = 1'b0;
        dmem_wr_d     = 1'b0;
        cfg_blocked_d = cfg_blocked_q;
        rd_high_d     = rd_high_q;
        byte_sel_d    = byte_sel_q;
        byte_mode_d   = byte_mode_q;
        remap_rd_d    = 1'b0;
        tbl_rd_d      = 1'b0;
        stall_d       = 1'b0;
        state_d       = state_q;
        pc_d          = pc_q;
        if (PC_ADVANCE) pc_d = pc_q + 24'h000002; // RULE_13
        case (state_q)
            pag_pkg::PAG_IDLE: begin
                if (table_busy) begin
                    prog_addr_d = table_addr; // RULE_01 RULE_06
                    prog_cfg_d  = is_cfg; // RULE_02
                    byte_sel_d  = EFFECTIVE_ADDRESS[0];
                    byte_mode_d = BYTE_MODE;
                    rd_high_d   = (op == pag_pkg::PAG_OP_RD_HIGH);
                    if (is_write) begin
                        if (is_cfg) begin
                            cfg_blocked_d = 1'b1; // RULE_11
                        end else begin
                            prog_wr_d = 1'b1;
                            if (op == pag_pkg::PAG_OP_WR_HIGH) begin
                                prog_wdata_d  = {TABLE_WDATA[7:0], 16'h0000}; // RULE_12
                                prog_wlanes_d = 3'b100;
                            end else if (BYTE_MODE) begin
                                prog_wdata_d  = {8'h00, TABLE_WDATA[7:0],
                                                 TABLE_WDATA[7:0]};
                                prog_wlanes_d = EFFECTIVE_ADDRESS[0] ?
                                                3'b010 : 3'b001;
                            end else begin
                                prog_wdata_d  = {8'h00, TABLE_WDATA};
                                prog_wlanes_d = 3'b011;
                            end
                        end
                    end else if (!is_cfg || cfg_impl) begin // RULE_11
                        prog_rd_d = 1'b1;
                        tbl_rd_d  = 1'b1;
                    end
                end else if (remap_hit) begin
                    prog_addr_d = remap_addr; // RULE_03 RULE_04
                    prog_rd_d   = 1'b1;
                    remap_rd_d  = 1'b1;
                    stall_d     = 1'b1; // RULE_16
                    state_d     = pag_pkg::PAG_REMAP_WAIT;
                end else if (DATA_REQ) begin
                    dmem_rd_d = !DATA_WRITE; // RULE_18
                    dmem_wr_d = DATA_WRITE; // RULE_18
                end else if (FETCH_REQ) begin
                    prog_rd_d = 1'b1; // RULE_05
                end
            end
            pag_pkg::PAG_REMAP_WAIT: begin
                state_d = pag_pkg::PAG_IDLE;
            end
            default: state_d = pag_pkg::PAG_IDLE;
        endcase
        core_rdata_d = core_rdata_q;
        if (remap_rd_q) core_rdata_d = PROG_RDATA[15:0]; // RULE_14
        if (tbl_rd_q)   core_rdata_d = steer_data;
    end
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q       <= pag_pkg::PAG_IDLE;
            pc_q          <= pag_pkg::PC_RST;
            PROG_ADDR     <= 24'h000000;
            PROG_RD       <= 1'b0;
            PROG_WR       <= 1'b0;
            PROG_CFG      <= 1'b0;
            PROG_WDATA    <= 24'h000000;
            PROG_WLANES   <= 3'b000;
            DMEM_ADDR     <= 16'h0000;
            DMEM_RD       <= 1'b0;
            DMEM_WR       <= 1'b0;
            CORE_STALL    <= 1'b0;
            cfg_blocked_q <= 1'b0;
            rd_high_q     <= 1'b0;
            byte_sel_q    <= 1'b0;
            byte_mode_q   <= 1'b0;
            remap_rd_q    <= 1'b0;
            tbl_rd_q      <= 1'b0;
            core_rdata_q  <= 16'h0000;
        end else begin
            state_q       <= state_d;
            pc_q          <= pc_d;
            PROG_ADDR     <= prog_addr_d;
            PROG_RD       <= prog_rd_d;
            PROG_WR       <= prog_wr_d;
            PROG_CFG      <= prog_cfg_d;
            PROG_WDATA    <= prog_wdata_d;
            PROG_WLANES   <= prog_wlanes_d;
            DMEM_ADDR     <= dmem_addr_d;
            DMEM_RD       <= dmem_rd_d;
            DMEM_WR       <= dmem_wr_d;
            CORE_STALL    <= stall_d;
            cfg_blocked_q <= cfg_blocked_d;
            rd_high_q     <= rd_high_d;
            byte_sel_q    <= byte_sel_d;
            byte_mode_q   <= byte_mode_d;
            remap_rd_q    <= remap_rd_d;
            tbl_rd_q      <= tbl_rd_d;
            core_rdata_q  <= core_rdata_d;
        end
    end
    assign PRDATA     = prdata_q;
    assign PREADY     = pready_q;
    assign PSLVERR    = pslverr_q;
    assign CORE_RDATA = core_rdata_q;
    // ==========================================================
    // checks
    sequence remap_req_s;
        DATA_REQ && !DATA_WRITE && !table_busy && program_window_enable
        && EFFECTIVE_ADDRESS[15] && state_q == pag_pkg::PAG_IDLE;
    endsequence
    sequence remap_issue_s;
        PROG_RD && !PROG_ADDR[23] && !PROG_ADDR[0] && CORE_STALL;
    endsequence
    remap_addr_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        remap_req_s |=> remap_issue_s ##0
        PROG_ADDR[15] == $past(remap_page_reg_q[0]) ##0
        PROG_ADDR[14:1] == $past(EFFECTIVE_ADDRESS[14:1])) // RULE_03
        else $error("remap address wrong");
    remap_stall_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        remap_req_s |=> CORE_STALL ##1 !CORE_STALL) // RULE_16
        else $error("remap stall not one cycle");
    table_addr_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (state_q == pag_pkg::PAG_IDLE && table_busy && !is_write)
        |=> PROG_ADDR == {$past(table_page_reg_q),
                          $past(EFFECTIVE_ADDRESS)}
            && PROG_CFG == $past(table_page_reg_q[7])) // RULE_01
        else $error("table address wrong");
    cfg_write_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        PROG_WR |-> !PROG_CFG) // RULE_11
        else $error("config write issued");
    no_remap_tbl_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        table_busy && state_q == pag_pkg::PAG_IDLE |=> !CORE_STALL) // RULE_17
        else $error("remap during table op");
    pc_step_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        PC_ADVANCE |=> pc_q == $past(pc_q) + 24'h000002) // RULE_13
        else $error("pc step wrong");
    phantom_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (tbl_rd_q && rd_high_q) |=> CORE_RDATA[15:8] == 8'h00) // RULE_09
        else $error("phantom byte not zero");
    hi_sel_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (tbl_rd_q && rd_high_q && byte_mode_q && byte_sel_q)
        |=> CORE_RDATA == 16'h0000) // RULE_10
        else $error("phantom select not zero");
    plain_data_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (DATA_REQ && !table_busy && state_q == pag_pkg::PAG_IDLE &&
         (!EFFECTIVE_ADDRESS[15] || !program_window_enable))
        |=> (DMEM_RD || DMEM_WR) &&
            DMEM_ADDR == $past(EFFECTIVE_ADDRESS)) // RULE_18
        else $error("plain data misrouted");
endmodule : pag_top

// ---- pkg/pag_pkg.sv ----
// program space address generation: shared constants and types
// assumes a 16-bit data space and a 24-bit program space
package pag_pkg;
    // ==========================================================
    // widths and field positions
    localparam int EA_W        = 16;
    localparam int PA_W        = 24;
    localparam int PAGE_W      = 8;
    localparam int DATA_W      = 16;
    localparam int EA_MSB      = 15;
    localparam int PAGE_CFG    = 7;
    localparam int WIN_EN_BIT  = 2;
    // ==========================================================
    // reset values
    localparam logic [7:0]  TABLE_PAGE_RST  = 8'h00;
    localparam logic [7:0]  REMAP_PAGE_RST  = 8'h00;
    localparam logic [15:0] CORE_CTRL_RST   = 16'h0000;
    localparam logic [23:0] PC_RST          = 24'h000000;
    // ==========================================================
    // timing: extra cycles for a read through the remap window
    localparam int REMAP_EXTRA_CYC = 1;
    // ==========================================================
    // register offsets (byte addresses on apb)
    localparam logic [11:0] TABLE_PAGE_OFS = 12'h000;
    localparam logic [11:0] REMAP_PAGE_OFS = 12'h004;
    localparam logic [11:0] CORE_CTRL_OFS  = 12'h008;
    localparam logic [11:0] STATUS_OFS     = 12'h00c;
    // implemented configuration area (byte address window, compared with bit 0 cleared)
    localparam logic [23:0] CFG_IMPL_LO    = 24'hff0000;
    localparam logic [23:0] CFG_IMPL_HI    = 24'hff0003;
    // ==========================================================
    typedef enum logic [2:0] {
        PAG_OP_NONE,
        PAG_OP_RD_LOW,
        PAG_OP_RD_HIGH,
        PAG_OP_WR_LOW,
        PAG_OP_WR_HIGH
    } pag_op_e;
    typedef enum {
        PAG_IDLE,
        PAG_REMAP_WAIT
    } pag_state_e;
endpackage : pag_pkg

// ---- tb/pag_mem_model.sv ----
// program memory model for the address generator bench
// assumes reads are strobed for one cycle; writes are only observed
`timescale 1ns/10ps
module pag_mem_model (
    input  wire logic        clk,
    input  wire logic        rd,
    input  wire logic [23:0] addr,
    output logic      [23:0] rdata
);
    logic [23:0] last_q = 24'h3c96a5;
    logic        was_rd_q = 1'b0;
    always_ff @(posedge clk) begin
        was_rd_q <= rd;
        last_q   <= rd ? rdata : ~last_q;
    end
    // word content follows the word address; last read word held one cycle after a read, garbage otherwise
    always_comb begin
        if (rd) begin
            rdata = {addr[8:1], addr[16:1]} ^ 24'h5ac3e1;
        end else if (was_rd_q) begin
            rdata = last_q;
        end else begin
            rdata = ~last_q;
        end
    end
endmodule : pag_mem_model

// ---- tb/tb.sv ----
// self-checking bench for the program space address generator
// assumes the memory model answers in the strobe cycle
`timescale 1ns/10ps
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    miscompares++; $display("unexpected at %0t: got %h expected %h", \
    $time, got, exp); end end
module tb;
    typedef struct {
        logic [32:0] ev;
        logic        chk;
        logic [15:0] data;
    } pag_note_s;
    logic MCLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA;
    logic PREADY, PSLVERR, CORE_STALL, PROG_RD, PROG_WR, PROG_CFG;
    logic FETCH_REQ = 0, PC_ADVANCE = 0, DATA_REQ = 0, DATA_WRITE = 0;
    logic BYTE_MODE = 0, DMEM_RD, DMEM_WR;
    logic [15:0] EFFECTIVE_ADDRESS = 0, TABLE_WDATA = 0, CORE_RDATA;
    logic [15:0] DMEM_ADDR, pend_d, ea;
    logic [2:0]  TABLE_OP = 0, PROG_WLANES;
    logic [23:0] PROG_ADDR, PROG_WDATA, PROG_RDATA, a, w;
    logic [7:0]  pg;
    logic [32:0] got, r;
    logic [23:0] got_w;
    int          miscompares = 0, n_tests = 0, pend = 0, cycles = 0, k;
    pag_note_s   qa[$];
    pag_note_s   n;
    logic [32:0] qr[$];

    pag_top pag_top_i (.MCLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FETCH_REQ, .PC_ADVANCE,
        .DATA_REQ, .DATA_WRITE, .EFFECTIVE_ADDRESS, .TABLE_OP, .BYTE_MODE,
        .TABLE_WDATA, .CORE_RDATA, .CORE_STALL, .PROG_ADDR, .PROG_RD,
        .PROG_WR, .PROG_CFG, .PROG_WDATA, .PROG_WLANES, .PROG_RDATA,
        .DMEM_ADDR, .DMEM_RD, .DMEM_WR);
    pag_mem_model pag_mem_model_i (.clk(MCLK), .rd(PROG_RD),
        .addr(PROG_ADDR), .rdata(PROG_RDATA));

    always #50 MCLK = ~MCLK;

    // ==========================================================
    // helpers
    function automatic logic [23:0] mem(logic [23:0] x);
        return {x[8:1], x[16:1]} ^ 24'h5ac3e1;
    endfunction : mem
    function automatic logic [15:0] steer(logic [23:0] v, logic hi,
                                          logic bm, logic bs);
        if (!bm) return hi ? {8'h00, v[23:16]} : v[15:0];
        if (hi) return {8'h00, bs ? 8'h00 : v[23:16]};
        return {8'h00, bs ? v[15:8] : v[7:0]};
    endfunction : steer
    // write data expected in the enabled lanes only
    function automatic logic [23:0] wexp(logic [2:0] ln, logic [15:0] d);
        if (ln[2]) return {d[7:0], 16'h0000};
        if (&ln[1:0]) return {8'h00, d};
        return ln[1] ? {8'h00, d[7:0], 8'h00} : {16'h0000, d[7:0]};
    endfunction : wexp
    task automatic tick(int c);
        repeat (c) @(posedge MCLK);
    endtask : tick
    task automatic apb(logic wr, logic [11:0] ad, logic [31:0] d,
                       logic [32:0] exp);
        qr.push_back(exp);
        PSEL   <= 1'b1;
        PWRITE <= wr;
        PADDR  <= ad;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask : apb
    task automatic core(logic [2:0] op, logic dreq, logic dwr,
                        logic [15:0] e, logic bm, logic fet,
                        logic [32:0] ev, logic chk, logic [15:0] d);
        if (ev != 0) qa.push_back('{ev, chk, d});
        TABLE_OP          <= op;
        DATA_REQ          <= dreq;
        DATA_WRITE        <= dwr;
        EFFECTIVE_ADDRESS <= e;
        BYTE_MODE         <= bm;
        FETCH_REQ         <= fet;
        TABLE_WDATA       <= d;
        @(posedge MCLK);
        TABLE_OP   <= 3'h0;
        DATA_REQ   <= 1'b0;
        DATA_WRITE <= 1'b0;
        FETCH_REQ  <= 1'b0;
        tick(4);
    endtask : core
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // monitor: memory strobes, read data and apb answers
    always @(negedge MCLK) begin
        if (pend == 1) `CHECK(CORE_RDATA, pend_d)
        if (pend > 0) pend--;
        if (PROG_RD | PROG_WR | DMEM_RD | DMEM_WR) begin
            n = qa.size() ? qa.pop_front() : pag_note_s'{33'h0, 1'b0, 16'h0};
            got = {PROG_RD, PROG_WR, PROG_CFG, CORE_STALL, DMEM_RD,
                DMEM_WR, PROG_WLANES & {3{PROG_WR}}, (PROG_RD | PROG_WR)
                ? PROG_ADDR : {8'h00, DMEM_ADDR}};
            `CHECK(got, n.ev)
            got_w = PROG_WDATA
                & {{8{n.ev[26]}}, {8{n.ev[25]}}, {8{n.ev[24]}}};
            if (PROG_WR) `CHECK(got_w, wexp(n.ev[26:24], n.data))
            if (n.chk) begin
                pend   = 2;
                pend_d = n.data;
            end
        end
        if (PREADY) begin
            r   = qr.pop_front();
            got = {PSLVERR, PRDATA & {32{!PWRITE}}};
            `CHECK(got, r)
        end
    end
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ==========================================================
    // stimulus
    initial begin
        void'($urandom(96596));
        tick(5);
        RESET_N <= 1'b1;
        tick(1);
        apb(0, pag_pkg::TABLE_PAGE_OFS, 0, 33'h0);
        apb(1, 12'h010, 32'h1, {1'b1, 32'h0});
        for (int i = 0; i < 16; i++) begin
            pg = 8'($urandom) & 8'h7f;
            ea = {15'($urandom), i[2]};
            a  = {pg, ea};
            apb(1, pag_pkg::TABLE_PAGE_OFS, {24'h0, pg}, 33'h0);
            core(i[0] ? pag_pkg::PAG_OP_RD_HIGH : pag_pkg::PAG_OP_RD_LOW,
                 0, 0, ea, i[1], 0, {9'h100, a}, 1,
                 steer(mem(a), i[0], i[1], ea[0]));
        end
        core(pag_pkg::PAG_OP_WR_LOW, 0, 0, ea, 0, 0, {9'h083, a}, 0,
             16'($urandom));
        core(pag_pkg::PAG_OP_WR_LOW, 0, 0, ea, 1, 0, {9'h082, a}, 0,
             16'($urandom));
        core(pag_pkg::PAG_OP_WR_HIGH, 0, 0, ea, 0, 0, {9'h084, a}, 0,
             16'($urandom));
        apb(1, pag_pkg::CORE_CTRL_OFS, 32'h4, 33'h0);
        apb(0, pag_pkg::CORE_CTRL_OFS, 0, 33'h4);
        core(pag_pkg::PAG_OP_RD_LOW, 1, 0, ea | 16'h8000, 0, 0,
             {9'h100, a | 24'h008000}, 1, 16'(mem(a | 24'h008000)));
        for (int i = 0; i < 8; i++) begin
            pg = 8'($urandom);
            ea = 16'($urandom) | 16'h8000;
            a  = {1'b0, pg, ea[14:1], 1'b0};
            w  = mem(a);
            apb(1, pag_pkg::REMAP_PAGE_OFS, {24'h0, pg}, 33'h0);
            apb(0, pag_pkg::REMAP_PAGE_OFS, 0, {25'h0, pg});
            core(0, 1, 0, ea, 0, 0, {9'h120, a}, 1, w[15:0]);
        end
        core(0, 1, 1, ea, 0, 0, {9'h008, 8'h0, ea}, 0, 0);
        core(0, 1, 0, ea & 16'h7fff, 0, 0,
             {9'h010, 8'h0, ea & 16'h7fff}, 0, 0);
        apb(1, pag_pkg::CORE_CTRL_OFS, 0, 33'h0);
        core(0, 1, 0, ea, 0, 0, {9'h010, 8'h0, ea}, 0, 0);
        apb(1, pag_pkg::TABLE_PAGE_OFS, 32'hff, 33'h0);
        w = mem(24'hff0003);
        core(pag_pkg::PAG_OP_RD_LOW, 0, 0, 16'h0003, 1, 0,
             {9'h140, 24'hff0003}, 1, {8'h00, w[15:8]});
        core(pag_pkg::PAG_OP_RD_LOW, 0, 0, 16'h0040, 0, 0, 0, 0, 0);
        core(pag_pkg::PAG_OP_WR_LOW, 0, 0, 16'h0002, 0, 0, 0, 0, 0);
        k = 1 + $urandom % 20;
        PC_ADVANCE <= 1'b1;
        tick(k);
        PC_ADVANCE <= 1'b0;
        a = 24'(2 * k);
        core(0, 0, 0, 0, 0, 1, {9'h100, a & 24'h7ffffe}, 0, 0);
        apb(0, pag_pkg::STATUS_OFS, 0, {8'h01, a});
        tick(4);
        `CHECK(qa.size() + qr.size(), 0)
        give_verdict();
    end
endmodule : tb
